// ===== hdl/eag_pkg.sv
// eag_pkg: shared constants and types for the effective-address generator
// assumes one core clock; no software-visible registers
package eag_pkg;

    // addressing forms handled by this unit
    typedef enum logic [1:0] {
        EAG_MODE_EXT,
        EAG_MODE_IX0,
        EAG_MODE_IX1,
        EAG_MODE_IX2
    } eag_mode_e;

    // operation classes that may reach the unit
    typedef enum logic [4:0] {
        EAG_OP_LOAD_A,
        EAG_OP_LOAD_X,
        EAG_OP_STORE_A,
        EAG_OP_STORE_X,
        EAG_OP_ADD,
        EAG_OP_ADD_C,
        EAG_OP_SUB,
        EAG_OP_SUB_C,
        EAG_OP_AND,
        EAG_OP_OR,
        EAG_OP_XOR,
        EAG_OP_CMP_A,
        EAG_OP_CMP_X,
        EAG_OP_BIT_TEST,
        EAG_OP_JUMP,
        EAG_OP_JUMP_SUB,
        EAG_OP_SHL,
        EAG_OP_SHR,
        EAG_OP_ASHR,
        EAG_OP_ROT_L,
        EAG_OP_ROT_R,
        EAG_OP_INCR,
        EAG_OP_DECR,
        EAG_OP_CLEAR,
        EAG_OP_COMPL,
        EAG_OP_NEGATE,
        EAG_OP_TEST
    } eag_op_e;

    // instruction lengths in bytes, opcode included
    localparam logic [1:0] EAG_LEN_EXT = 2'h3;
    localparam logic [1:0] EAG_LEN_IX0 = 2'h1;
    localparam logic [1:0] EAG_LEN_IX1 = 2'h2;
    localparam logic [1:0] EAG_LEN_IX2 = 2'h3;

    // reset values, and the zero high byte for no-offset and 8-bit offset addresses
    localparam logic [15:0] EAG_ADDR_RST = 16'h0000;
    localparam logic [7:0] EAG_BYTE_RST = 8'h00;
    localparam logic [7:0] EAG_PAGE0_HI = 8'h00;

endpackage

// ===== hdl/eag_addr_gen.sv
// eag_addr_gen: effective address and length for extended and indexed forms
// assumes request, operand bytes and index come from core logic on the same clock
//
// Functional notes
// - extended address is first operand byte high, second byte low.
// - extended instruction is three bytes; program counter advances by three.
// - extended form allowed for load/store/arith/logic/compare/bit/jump, not read-modify-write.
// - no-offset indexed address is index in low byte, high byte zero.
// - no-offset indexed instruction is one byte; counter advances by one.
// - 8-bit offset plus index, unsigned, carry kept, up to 01FE.
// - 8-bit offset indexed instruction is two bytes; counter advances by two.
// - 16-bit offset high byte first, then low, plus unsigned index.
// - 16-bit offset indexed instruction is three bytes; counter advances by three.
// - read-modify-write allows only no-offset and 8-bit offset indexed forms.
`timescale 1ns/1ps

module eag_addr_gen
    import eag_pkg::*;
(
    input wire logic REF_CLK_IN, // core clock, 20 MHz
    input wire logic RESETN_IN, // synchronous reset, active low
    input wire logic CE_IN, // clock enable, freezes all state when low
    input wire logic START_IN, // pulse: new instruction decoded
    input wire logic [1:0] MODE_IN, // addressing form, eag_mode_e
    input wire logic [4:0] OP_IN, // operation class, eag_op_e
    input wire logic [7:0] INDEX_IN, // index register contents
    input wire logic [15:0] PC_IN, // address of the opcode byte
    input wire logic BYTE_VALID_IN, // operand byte present
    input wire logic [7:0] BYTE_IN, // operand byte following the opcode
    output logic BUSY_OUT, // level: request in progress
    output logic BYTE_REQ_OUT, // level: waiting for an operand byte
    output logic ADDR_VALID_OUT, // pulse: address result ready
    output logic [15:0] ADDR_OUT, // effective operand address
    output logic [1:0] LEN_OUT, // instruction length in bytes
    output logic [15:0] NEXT_PC_OUT, // address of the next opcode
    output logic REJECT_OUT // pulse: form not offered for this operation
);

    ////////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // true for the read-modify-write class
    function automatic logic is_rmw(input logic [4:0] op);
        logic r;
        r = 1'b0;
        case (eag_op_e'(op))
            EAG_OP_SHL, EAG_OP_SHR, EAG_OP_ASHR, EAG_OP_ROT_L, EAG_OP_ROT_R,
            EAG_OP_INCR, EAG_OP_DECR, EAG_OP_CLEAR, EAG_OP_COMPL, EAG_OP_NEGATE,
            EAG_OP_TEST: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // true when the operation code is a known class
    function automatic logic is_known(input logic [4:0] op);
        return op <= 5'(EAG_OP_TEST);
    endfunction

    // whether an operation accepts the given addressing form
    function automatic logic form_ok(input logic [1:0] mode, input logic [4:0] op);
        logic r;
        r = 1'b0;
        case (eag_mode_e'(mode))
            EAG_MODE_EXT: r = is_known(op) && !is_rmw(op);
            EAG_MODE_IX0: r = is_known(op);
            EAG_MODE_IX1: r = is_known(op);
            EAG_MODE_IX2: r = is_known(op) && !is_rmw(op);
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // instruction length for each form
    function automatic logic [1:0] form_len(input logic [1:0] mode);
        logic [1:0] r;
        r = EAG_LEN_IX0;
        case (eag_mode_e'(mode))
            EAG_MODE_EXT: r = EAG_LEN_EXT;
            EAG_MODE_IX0: r = EAG_LEN_IX0;
            EAG_MODE_IX1: r = EAG_LEN_IX1;
            EAG_MODE_IX2: r = EAG_LEN_IX2;
            default: r = EAG_LEN_IX0;
        endcase
        return r;
    endfunction

    // widens a byte to an address word with a zero high byte
    function automatic logic [15:0] zext(input logic [7:0] b);
        return {EAG_PAGE0_HI, b};
    endfunction

    // adds an unsigned byte to an address word; the carry out of bit 15 is dropped
    function automatic logic [15:0] add_wrap(input logic [15:0] base, input logic [7:0] b);
        logic [16:0] s;
        s = {1'b0, base} + {1'b0, zext(b)};
        return s[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    // request progress; the no-offset form never leaves idle
    typedef enum logic [1:0] {
        EAG_ST_IDLE,
        EAG_ST_FIRST,
        EAG_ST_SECOND
    } eag_state_e;

    // sequencing group: where the unit is in a request
    eag_state_e state_q, state_d;
    logic busy_q, busy_d;
    logic req_q, req_d;

    // capture group: request fields held while operand bytes arrive
    logic [1:0] mode_q, mode_d;
    logic [7:0] index_q, index_d;
    logic [7:0] first_q, first_d;

    // result group: what the core sees on the outputs
    logic valid_q, valid_d;
    logic [15:0] addr_q, addr_d;
    logic [1:0] len_q, len_d;
    logic [15:0] pc_q, pc_d;
    logic reject_q, reject_d;

    // decode of the current cycle, shared by the groups
    logic start_take;
    logic start_legal;
    logic start_bad;
    logic byte_first;
    logic byte_second;
    logic short_done;
    logic [15:0] long_word;

    ////////////////////////////////////////////////////////////////////////////
    // request and byte decode

    // a start counts only while idle; a busy unit ignores it without complaint
    assign start_take = START_IN && (state_q == EAG_ST_IDLE);
    // the form must be offered for the operation class, else the request is refused
    assign start_legal = start_take && form_ok(MODE_IN, OP_IN);
    assign start_bad = start_take && !form_ok(MODE_IN, OP_IN);
    // operand bytes count only while the unit asks for them; stray bytes are dropped
    assign byte_first = BYTE_VALID_IN && (state_q == EAG_ST_FIRST);
    assign byte_second = BYTE_VALID_IN && (state_q == EAG_ST_SECOND);
    // the 8-bit offset form ends on its only operand byte
    assign short_done = byte_first && (eag_mode_e'(mode_q) == EAG_MODE_IX1);
    // held first byte is the high half, the byte on the bus now the low half
    assign long_word = {first_q, BYTE_IN};

    ////////////////////////////////////////////////////////////////////////////
    // sequencing: idle, waiting for the first byte, waiting for the second

    // next state; the no-offset form and refused requests never leave idle
    always_comb begin
        state_d = state_q;
        busy_d = busy_q;
        req_d = req_q;
        case (state_q)
            EAG_ST_IDLE: begin
                // a legal start of a form with operand bytes opens the wait
                if (start_legal && (eag_mode_e'(MODE_IN) != EAG_MODE_IX0)) begin
                    state_d = EAG_ST_FIRST;
                    busy_d = 1'b1;
                    req_d = 1'b1;
                end
            end
            EAG_ST_FIRST: begin
                // the first byte ends the 8-bit form, otherwise it opens the second wait
                if (short_done) begin
                    state_d = EAG_ST_IDLE;
                    busy_d = 1'b0;
                    req_d = 1'b0;
                end else if (byte_first) begin
                    state_d = EAG_ST_SECOND;
                end
            end
            EAG_ST_SECOND: begin
                // the second byte always ends the request
                if (byte_second) begin
                    state_d = EAG_ST_IDLE;
                    busy_d = 1'b0;
                    req_d = 1'b0;
                end
            end
            default: begin
                state_d = EAG_ST_IDLE;
                busy_d = 1'b0;
                req_d = 1'b0;
            end
        endcase
    end

    // sequencing registers; a low enable holds them, reset does not wait for it
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            state_q <= EAG_ST_IDLE;
            busy_q <= 1'b0;
            req_q <= 1'b0;
        end else if (CE_IN) begin
            state_q <= state_d;
            busy_q <= busy_d;
            req_q <= req_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // capture of the request fields

    // form and index are taken with the start, so a later index change has no effect
    always_comb begin
        mode_d = mode_q;
        index_d = index_q;
        first_d = first_q;
        if (start_take) begin
            mode_d = MODE_IN;
            index_d = INDEX_IN;
        end
        if (byte_first) begin
            first_d = BYTE_IN;
        end
    end

    // capture registers
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            mode_q <= 2'(EAG_MODE_EXT);
            index_q <= EAG_BYTE_RST;
            first_q <= EAG_BYTE_RST;
        end else if (CE_IN) begin
            mode_q <= mode_d;
            index_q <= index_d;
            first_q <= first_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result: length, next opcode address, effective address, refusal

    // pulses default low; address, length and next pc hold until replaced
    always_comb begin
        valid_d = 1'b0;
        addr_d = addr_q;
        len_d = len_q;
        pc_d = pc_q;
        reject_d = 1'b0;
        // a refused request leaves length, next pc and address untouched
        if (start_bad) begin
            reject_d = 1'b1;
        end
        // length and next opcode address are known as soon as the form is
        if (start_legal) begin
            len_d = form_len(MODE_IN);
            pc_d = PC_IN + 16'(form_len(MODE_IN));
            if (eag_mode_e'(MODE_IN) == EAG_MODE_IX0) begin
                addr_d = zext(INDEX_IN);
                valid_d = 1'b1;
            end
        end
        // 8-bit offset: byte plus index, carry kept into the high byte
        if (short_done) begin
            addr_d = add_wrap(zext(BYTE_IN), index_q);
            valid_d = 1'b1;
        end
        // extended takes the word as is; 16-bit offset adds the index and wraps
        if (byte_second) begin
            if (eag_mode_e'(mode_q) == EAG_MODE_IX2) begin
                addr_d = add_wrap(long_word, index_q);
            end else begin
                addr_d = long_word;
            end
            valid_d = 1'b1;
        end
    end

    // result registers; a low enable also stretches the one-cycle pulses
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            valid_q <= 1'b0;
            addr_q <= EAG_ADDR_RST;
            len_q <= EAG_LEN_IX0;
            pc_q <= EAG_ADDR_RST;
            reject_q <= 1'b0;
        end else if (CE_IN) begin
            valid_q <= valid_d;
            addr_q <= addr_d;
            len_q <= len_d;
            pc_q <= pc_d;
            reject_q <= reject_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, each straight from a flip-flop

    // handshake and status
    assign BUSY_OUT = busy_q;
    assign BYTE_REQ_OUT = req_q;
    assign ADDR_VALID_OUT = valid_q;
    assign REJECT_OUT = reject_q;

    // results that hold until the next update
    assign ADDR_OUT = addr_q;
    assign LEN_OUT = len_q;
    assign NEXT_PC_OUT = pc_q;

endmodule // eag_addr_gen

// ===== bench/eag_addr_gen_assertions.sv
// eag_addr_gen_assertions: port checks of the address generator
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/1ps
module eag_addr_gen_chk (
    input wire logic REF_CLK_IN, // clock
    input wire logic RESETN_IN, // reset
    input wire logic CE_IN, // enable
    input wire logic START_IN, // request
    input wire logic [1:0] MODE_IN, // form
    input wire logic [4:0] OP_IN, // class
    input wire logic [7:0] INDEX_IN, // index
    input wire logic [15:0] PC_IN, // pc
    input wire logic BYTE_VALID_IN, // strobe
    input wire logic [7:0] BYTE_IN, // byte
    input wire logic BUSY_OUT, // busy
    input wire logic BYTE_REQ_OUT, // wants byte
    input wire logic ADDR_VALID_OUT, // result
    input wire logic [15:0] ADDR_OUT, // address
    input wire logic [1:0] LEN_OUT, // length
    input wire logic [15:0] NEXT_PC_OUT, // next pc
    input wire logic REJECT_OUT // refused
);
    default clocking @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);
    // request taken, operand byte taken
    wire logic tk = START_IN && !BUSY_OUT && CE_IN;
    wire logic bt = BYTE_VALID_IN && BYTE_REQ_OUT && CE_IN;
    ////////////////////////////////////////
    a_ext_len: assert property (
        tk && MODE_IN == 2'h0 && OP_IN < 5'h10 |=> BUSY_OUT && LEN_OUT == 2'h3 && NEXT_PC_OUT == $past(PC_IN) + 16'h0003)
        else $error("extended length wrong");
    a_ext_addr: assert property (
        tk && MODE_IN == 2'h0 && OP_IN < 5'h10 ##1 bt ##1 bt |=> ADDR_VALID_OUT && ADDR_OUT == {$past(BYTE_IN, 2), $past(BYTE_IN)})
        else $error("extended address wrong");
    a_ext_refuse: assert property (
        tk && MODE_IN == 2'h0 && OP_IN > 5'h0f |=> REJECT_OUT && !BUSY_OUT && $stable(NEXT_PC_OUT))
        else $error("extended form not refused");
    a_ix0_addr: assert property (
        tk && MODE_IN == 2'h1 && OP_IN < 5'h1b |=> ADDR_VALID_OUT && ADDR_OUT == {8'h00, $past(INDEX_IN)}
            && LEN_OUT == 2'h1 && NEXT_PC_OUT == $past(PC_IN) + 16'h0001) else $error("no-offset result wrong");
    a_ix1_len: assert property (
        tk && MODE_IN == 2'h2 && OP_IN < 5'h1b |=> BUSY_OUT && !REJECT_OUT && LEN_OUT == 2'h2 && NEXT_PC_OUT == $past(PC_IN) + 16'h0002)
        else $error("short offset length wrong");
    a_ix1_addr: assert property (
        tk && MODE_IN == 2'h2 && OP_IN < 5'h1b ##1 bt |=> ADDR_VALID_OUT && ADDR_OUT == $past(BYTE_IN) + $past(INDEX_IN, 2))
        else $error("short offset address wrong");
    a_ix2_len: assert property (
        tk && MODE_IN == 2'h3 && OP_IN < 5'h10 |=> LEN_OUT == 2'h3 && NEXT_PC_OUT == $past(PC_IN) + 16'h0003)
        else $error("long offset length wrong");
    a_ix2_addr: assert property (
        tk && MODE_IN == 2'h3 && OP_IN < 5'h10 ##1 bt ##1 bt |=> ADDR_VALID_OUT
            && ADDR_OUT == {$past(BYTE_IN, 2), $past(BYTE_IN)} + $past(INDEX_IN, 3)) else $error("long offset address wrong");
    a_ix2_refuse: assert property (
        tk && MODE_IN == 2'h3 && OP_IN > 5'h0f |=> REJECT_OUT && !ADDR_VALID_OUT && $stable(LEN_OUT))
        else $error("long offset form not refused");
endmodule // eag_addr_gen_chk
bind eag_addr_gen eag_addr_gen_chk u_chk (.REF_CLK_IN(REF_CLK_IN), .RESETN_IN(RESETN_IN), .CE_IN(CE_IN),
    .START_IN(START_IN), .MODE_IN(MODE_IN), .OP_IN(OP_IN), .INDEX_IN(INDEX_IN), .PC_IN(PC_IN),
    .BYTE_VALID_IN(BYTE_VALID_IN), .BYTE_IN(BYTE_IN), .BUSY_OUT(BUSY_OUT), .BYTE_REQ_OUT(BYTE_REQ_OUT),
    .ADDR_VALID_OUT(ADDR_VALID_OUT), .ADDR_OUT(ADDR_OUT), .LEN_OUT(LEN_OUT), .NEXT_PC_OUT(NEXT_PC_OUT),
    .REJECT_OUT(REJECT_OUT));

// ===== bench/eag_addr_gen_tb.sv
// eag_addr_gen_tb: self-checking bench for the address generator
// assumes the package and design are compiled first; bench drives all ports
`timescale 1ns/1ps
module eag_addr_gen_tb import eag_pkg::*;;
    logic REF_CLK_IN = 1'h0, RESETN_IN = 1'h0, CE_IN = 1'h1, START_IN = 1'h0, BYTE_VALID_IN = 1'h0;
    logic [1:0] MODE_IN = 2'h0;
    logic [4:0] OP_IN = 5'h00;
    logic [7:0] INDEX_IN = 8'h00, BYTE_IN = 8'h00;
    logic [15:0] PC_IN = 16'h0000, l;
    logic BUSY_OUT, BYTE_REQ_OUT, ADDR_VALID_OUT, REJECT_OUT;
    logic [15:0] ADDR_OUT, NEXT_PC_OUT;
    logic [1:0] LEN_OUT;
    int mismatches = 0, n_checks = 0;
    typedef struct {logic [1:0] m; logic [4:0] op; logic [7:0] x, hi, lo; logic [15:0] pc, a;} eag_row_s;
    // form, class, index, bytes, pc, expected address
    eag_row_s rows [6] = '{'{2'h0, 5'h00, 8'h55, 8'h12, 8'h34, 16'h1000, 16'h1234},
        '{2'h0, 5'h0f, 8'h00, 8'hff, 8'hff, 16'hfffe, 16'hffff}, '{2'h1, 5'h1a, 8'hff, 8'h00, 8'h00, 16'h0200, 16'h00ff},
        '{2'h2, 5'h15, 8'hff, 8'hff, 8'h00, 16'h0300, 16'h01fe}, '{2'h2, 5'h02, 8'h00, 8'h00, 8'h00, 16'h0400, 16'h0000},
        '{2'h3, 5'h04, 8'hff, 8'hff, 8'h80, 16'h0500, 16'h007f}};
    eag_addr_gen u_eag_addr_gen (.REF_CLK_IN(REF_CLK_IN), .RESETN_IN(RESETN_IN), .CE_IN(CE_IN), .START_IN(START_IN),
        .MODE_IN(MODE_IN), .OP_IN(OP_IN), .INDEX_IN(INDEX_IN), .PC_IN(PC_IN), .BYTE_VALID_IN(BYTE_VALID_IN),
        .BYTE_IN(BYTE_IN), .BUSY_OUT(BUSY_OUT), .BYTE_REQ_OUT(BYTE_REQ_OUT), .ADDR_VALID_OUT(ADDR_VALID_OUT),
        .ADDR_OUT(ADDR_OUT), .LEN_OUT(LEN_OUT), .NEXT_PC_OUT(NEXT_PC_OUT), .REJECT_OUT(REJECT_OUT));
    // 50 ns core clock
    always #25 REF_CLK_IN = ~REF_CLK_IN;
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one request, feeding bytes while asked, until result or refusal
    task automatic req(input logic [1:0] m, input logic [4:0] op, input logic [7:0] x, hi, lo, input logic [15:0] pc);
        int n;
        n = 0;
        {MODE_IN, OP_IN, INDEX_IN, PC_IN, START_IN} = {m, op, x, pc, 1'h1};
        @(posedge REF_CLK_IN) #1;
        START_IN = 1'h0;
        for (int i = 0; i < 8 && ADDR_VALID_OUT !== 1'h1 && REJECT_OUT !== 1'h1; i++) begin
            BYTE_VALID_IN = BYTE_REQ_OUT;
            BYTE_IN = n ? lo : hi;
            n = n + BYTE_REQ_OUT;
            @(posedge REF_CLK_IN) #1;
        end
        BYTE_VALID_IN = 1'h0;
    endtask
    task automatic results();
        if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    // watchdog
    initial begin
        #200_000;
        mismatches++;
        results();
    end
    // main sequence
    initial begin
        repeat (5) @(posedge REF_CLK_IN);
        #1 RESETN_IN = 1'h1;
        chk("len_rst", 16'h0001, LEN_OUT);
        chk("req_rst0", 16'h0000, BYTE_REQ_OUT);
        foreach (rows[i]) begin
            req(rows[i].m, rows[i].op, rows[i].x, rows[i].hi, rows[i].lo, rows[i].pc);
            l = rows[i].m == 2'h1 ? 16'h0001 : rows[i].m == 2'h2 ? 16'h0002 : 16'h0003;
            chk("valid", 16'h0001, ADDR_VALID_OUT);
            chk("addr", rows[i].a, ADDR_OUT);
            chk("len", l, LEN_OUT);
            chk("next_pc", rows[i].pc + l, NEXT_PC_OUT);
        end
        // every form against every class code
        for (int m = 0; m < 4; m++)
            for (int o = 0; o < 32; o++) begin
                req(m[1:0], o[4:0], 8'h10, 8'h20, 8'h30, 16'h0100);
                chk("reject", o > 26 || (m % 3 == 0 && o > 15), REJECT_OUT);
            end
        // no-offset requests back to back
        {MODE_IN, OP_IN, START_IN} = {2'h1, 5'h10, 1'h1};
        for (int k = 0; k < 3; k++) begin
            INDEX_IN = 8'h80 + k[7:0];
            @(posedge REF_CLK_IN) #1;
            chk("b2b_addr", {8'h00, 8'h80 + k[7:0]}, ADDR_OUT);
            chk("b2b_valid", 16'h0001, ADDR_VALID_OUT);
        end
        // enable low freezes an 8-bit offset request that waits for its byte
        {MODE_IN, OP_IN, INDEX_IN} = {2'h2, 5'h00, 8'h90};
        @(posedge REF_CLK_IN) #1;
        {START_IN, CE_IN, BYTE_VALID_IN, BYTE_IN} = {1'h0, 1'h0, 1'h1, 8'h05};
        repeat (2) @(posedge REF_CLK_IN);
        #1 chk("ce_req", 16'h0001, BYTE_REQ_OUT);
        CE_IN = 1'h1;
        @(posedge REF_CLK_IN) #1;
        BYTE_VALID_IN = 1'h0;
        chk("ce_addr", 16'h0095, ADDR_OUT);
        // reset in the middle of an extended request
        {MODE_IN, OP_IN, START_IN} = {2'h0, 5'h00, 1'h1};
        @(posedge REF_CLK_IN) #1;
        {START_IN, RESETN_IN} = 2'h0;
        chk("busy", 16'h0001, BUSY_OUT);
        @(posedge REF_CLK_IN) #1;
        RESETN_IN = 1'h1;
        chk("busy_rst", 16'h0000, BUSY_OUT);
        chk("req_rst", 16'h0000, BYTE_REQ_OUT);
        results();
    end
endmodule // eag_addr_gen_tb
